// *** design/fnp_packer.sv ***
// Narrow-to-wide packer with a two-entry output buffer and APB control.
// Assumes the source and consumer run on pclk; the core is single clock.
`timescale 1ns/100ps

// Overview of operation
// - x20 two, x10 four slices per wide read
// - x10 single rate, eight slices per double read
// - Match on, 20-bit slices from low lines
// - First x20 slice high half, second low
// - All selects high: double in, double out
// - Four bytes fill 39:30 down to 9:0
// - Single rate x10: four bytes one word
// - Double read: first word rise, second fall
module fnp_packer (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire fnp_pkg::fnp_in_t  in_data,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output fnp_pkg::fnp_out_t      out_data
);
	import fnp_pkg::*;

	typedef struct packed {
		fnp_cfg_t              cfg;
		logic [FNP_WORD_W-1:0] acc;
		logic [2:0]            slices;
		logic [FNP_WORD_W-1:0] ent0;
		logic [FNP_WORD_W-1:0] ent1;
		logic [1:0]            level;
		logic                  out_valid;
		logic                  in_ready;
		logic [15:0]           words;
		logic [31:0]           rdata;
		logic                  ready;
		logic                  slverr;
	} fnp_state_t;

	fnp_state_t state_q;
	fnp_state_t state_d;

	// Combinational helpers
	logic [2:0]            need;
	logic [1:0]            beats;
	logic [1:0]            max_done;
	logic [1:0]            pop_n;
	logic                  take;
	logic                  pop;
	logic                  wr_ctrl;
	logic                  mode_ok;
	logic [FNP_WORD_W-1:0] beat;
	logic [FNP_WORD_W-1:0] ents [FNP_DEPTH];
	logic [1:0]            lvl;
	logic [2:0]            sl;
	logic [FNP_WORD_W-1:0] acc;

	// Mode decode; slice count per wide word
	always_comb begin
		if (!state_q.cfg.width_match_enable) begin
			need = FNP_SLICES_X40;
		end else if (state_q.cfg.byte_width_select) begin
			need = FNP_SLICES_X10;
		end else begin
			need = FNP_SLICES_X20;
		end
		beats    = state_q.cfg.write_rate_select ? 2'd2 : 2'd1;
		pop_n    = state_q.cfg.read_rate_select ? 2'd2 : 2'd1;
		// Worst case of words finished in one write cycle
		max_done = (need == FNP_SLICES_X40) ? beats : 2'd1;
		// x20 packing must put the narrow side on the write port
		mode_ok  = !(state_q.cfg.width_match_enable && state_q.cfg.narrow_side_select
			&& !state_q.cfg.byte_width_select);
	end

	// Handshakes
	assign take    = in_valid && state_q.in_ready;
	assign pop     = out_ready && state_q.out_valid;
	assign wr_ctrl = psel && penable && state_q.ready && pwrite
		&& (paddr == FNP_CTRL_OFS);

	// Next state: buffer drain, slice packing, counters, APB
	always_comb begin
		state_d = state_q;
		ents[0] = state_q.ent0;
		ents[1] = state_q.ent1;
		lvl     = state_q.level;
		sl      = state_q.slices;
		acc     = state_q.acc;
		beat    = '0;

		// Drain first; the rising word always leaves first
		if (pop) begin
			if (pop_n == 2'd2) begin
				lvl = 2'd0;
			end else begin
				ents[0] = ents[1];
				lvl     = lvl - 2'd1;
			end
		end

		// Beats in arrival order, rising beat before falling beat
		if (take) begin
			for (int b = 0; b < 2; b++) begin
				if (b < int'(beats)) begin
					beat = (b == 0) ? in_data.beat_rise : in_data.beat_fall;
					if (need == FNP_SLICES_X40) begin
						acc = beat;
					end else if (need == FNP_SLICES_X10) begin
						acc = {acc[29:0], beat[9:0]};
					end else begin
						acc = {acc[19:0], beat[19:0]};
					end
					sl = sl + 3'd1;
					// Complete words only; partial stays in acc
					if (sl == need) begin
						ents[lvl[0]] = acc;
						lvl          = lvl + 2'd1;
						sl           = 3'd0;
						// Two words can finish in one double-rate write cycle
						state_d.words = state_d.words + 16'd1;
					end
				end
			end
		end

		// A new configuration discards any half-built word
		if (wr_ctrl) begin
			state_d.cfg = fnp_cfg_t'(pwdata[FNP_CTRL_BITS-1:0]);
			sl          = 3'd0;
			acc         = '0;
		end

		state_d.ent0   = ents[0];
		state_d.ent1   = ents[1];
		state_d.level  = lvl;
		state_d.slices = sl;
		state_d.acc    = acc;
		// Double read presents only whole pairs
		state_d.out_valid = (pop_n == 2'd2) ? (lvl == FNP_LEVEL_FULL) : (lvl != 2'd0);
		// Conservative: room for every word that could finish next cycle
		state_d.in_ready  = ((FNP_LEVEL_FULL - lvl) >= max_done) && !wr_ctrl;

		// APB: answer in the first access cycle, decode at setup
		state_d.ready  = psel && !penable;
		state_d.slverr = 1'b0;
		if (psel && !penable) begin
			state_d.rdata = FNP_RDATA_RESET;
			unique case (paddr)
				FNP_CTRL_OFS: begin
					state_d.rdata[FNP_CTRL_BITS-1:0] = state_q.cfg;
				end
				FNP_STATUS_OFS: begin
					state_d.rdata[FNP_STAT_LEVEL +: 2] = state_q.level;
					state_d.rdata[FNP_STAT_SLICE +: 3] = state_q.slices;
					state_d.rdata[FNP_STAT_MODE]       = mode_ok;
				end
				FNP_WORDS_OFS: begin
					state_d.rdata[15:0] = state_q.words;
				end
				default: begin
					state_d.slverr = 1'b1; // Unmapped address
				end
			endcase
		end
	end

	// State register; constants only under reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q           <= '0;
			state_q.cfg       <= fnp_cfg_t'(FNP_CTRL_RESET);
			state_q.words     <= FNP_WORDS_RESET;
			state_q.rdata     <= FNP_RDATA_RESET;
			state_q.in_ready  <= 1'b1;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs straight from the state flops
	assign prdata             = state_q.rdata;
	assign pready             = state_q.ready;
	assign pslverr            = state_q.slverr;
	assign in_ready           = state_q.in_ready;
	assign out_valid          = state_q.out_valid;
	assign out_data.word_rise = state_q.ent0;
	assign out_data.word_fall = state_q.ent1;

endmodule // fnp_packer

// *** design/fnp_pkg.sv ***
// Package for the narrow-to-wide packer: register map, field layout, carriers.
// Assumes an APB master with 32-bit data and one aligned word per register.
package fnp_pkg;

	// Register byte offsets
	localparam logic [7:0] FNP_CTRL_OFS   = 8'h00;
	localparam logic [7:0] FNP_STATUS_OFS = 8'h04;
	localparam logic [7:0] FNP_WORDS_OFS  = 8'h08;

	// Control field positions
	localparam int FNP_CTRL_WRATE  = 0;
	localparam int FNP_CTRL_RRATE  = 1;
	localparam int FNP_CTRL_MATCH  = 2;
	localparam int FNP_CTRL_NARROW = 3;
	localparam int FNP_CTRL_BYTE   = 4;
	localparam int FNP_CTRL_BITS   = 5;
	localparam logic [4:0] FNP_CTRL_RESET = 5'h00;

	// Status field positions
	localparam int FNP_STAT_LEVEL = 0;  // 2 bits, buffer fill
	localparam int FNP_STAT_SLICE = 4;  // 3 bits, slices held in the packer
	localparam int FNP_STAT_MODE  = 8;  // 1 bit, set unless x20 packing has the narrow side on read

	// Widths and counts
	localparam int FNP_WORD_W   = 40;
	localparam int FNP_DEPTH    = 2;
	localparam logic [2:0] FNP_SLICES_X10 = 3'd4;
	localparam logic [2:0] FNP_SLICES_X20 = 3'd2;
	localparam logic [2:0] FNP_SLICES_X40 = 3'd1;
	localparam logic [1:0] FNP_LEVEL_FULL = 2'd2;
	localparam logic [15:0] FNP_WORDS_RESET = 16'h0000;
	localparam logic [31:0] FNP_RDATA_RESET = 32'h0000_0000;

	// Static configuration
	typedef struct packed {
		logic byte_width_select;   // 10-bit slices instead of 20-bit
		logic narrow_side_select;  // narrow side is the read side
		logic width_match_enable;  // pack slices into 40-bit words
		logic read_rate_select;    // two words per read cycle
		logic write_rate_select;   // two slices per write cycle
	} fnp_cfg_t;

	// Write side: two beats, the first stands for the rising edge
	typedef struct packed {
		logic [FNP_WORD_W-1:0] beat_fall;
		logic [FNP_WORD_W-1:0] beat_rise;
	} fnp_in_t;

	// Read side: rising-edge word first, falling-edge word second
	typedef struct packed {
		logic [FNP_WORD_W-1:0] word_fall;
		logic [FNP_WORD_W-1:0] word_rise;
	} fnp_out_t;

endpackage

// *** tb/fifo_narrow_to_wide_packer_bench.sv ***
// Self-checking bench for fnp_packer: packing modes, partial words, stall.
// Assumes fnp_sink as reader and the checker bound from its own file.
`timescale 1ns/100ps
module fifo_narrow_to_wide_packer_bench;
	import fnp_pkg::*;
	typedef struct {logic [4:0] cfg; int spw; int nw;} fnp_row_t;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, in_valid = 0;
	logic        pready, pslverr, in_ready, out_valid, out_ready, err, rrate = 0, hold = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [39:0] exp;
	fnp_in_t     in_data = '0;
	fnp_out_t    out_data;
	int          fail_count = 0, checks_done = 0, n, k;
	// Mode, slices per word, words per read
	fnp_row_t rows[5] = '{'{5'h04,2,1}, '{5'h06,2,2}, '{5'h1c,4,1}, '{5'h1e,4,2}, '{5'h1f,4,2}};
	fnp_packer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
	fnp_sink sink_u (.pclk(pclk), .out_valid(out_valid), .out_data(out_data), .rrate(rrate),
		.hold(hold), .out_ready(out_ready));
	initial forever #5 pclk = ~pclk;
	function automatic logic [39:0] sv(int i);
		return 40'h00_0000_0155 + i * 40'h00_0000_0011;
	endfunction
	task automatic chk(logic [39:0] got, logic [39:0] want);
		checks_done++;
		if (got !== want) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Bounded wait, judged at negedge so registered flags are settled
	task automatic await(int s, int need);
		int t;
		for (t = 0; t < 300; t++) begin
			@(negedge pclk);
			if ((s == 0 && pready) || (s == 1 && in_ready) || (s == 2 && sink_u.got.size() >= need))
				break;
		end
		if (t == 300) begin
			fail_count++;
			final_report();
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int t;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// Answer taken at the rising edge that samples pready high
		for (t = 0; t < 300; t++) begin
			@(posedge pclk);
			if (pready)
				break;
		end
		if (t == 300) begin
			fail_count++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic send(logic [39:0] r, logic [39:0] f);
		@(posedge pclk);
		in_valid <= 1;
		in_data <= {f, r};
		await(1, 0);
		@(posedge pclk);
		in_valid <= 0;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		apb(0, FNP_CTRL_OFS, 0);
		chk(rd, 0);
		apb(0, FNP_WORDS_OFS, 0);
		chk(rd, 0);
		apb(0, 8'h40, 0);
		chk({rd, err}, 1);
		// Five packing modes, expected words packed here
		foreach (rows[r]) begin
			rrate <= rows[r].cfg[1];
			apb(1, FNP_CTRL_OFS, {27'h000_0000, rows[r].cfg});
			n = rows[r].spw * rows[r].nw;
			for (k = 0; k < n; k += rows[r].cfg[0] ? 2 : 1)
				send(sv(k), rows[r].cfg[0] ? sv(k + 1) : 40'h00_0000_0000);
			await(2, rows[r].nw);
			for (int w = 0; w < rows[r].nw; w++) begin
				exp = 0;
				for (int j = 0; j < rows[r].spw; j++)
					exp = (exp << (40 / rows[r].spw)) | sv(w * rows[r].spw + j);
				chk(sink_u.got.pop_front(), exp);
			end
			$display("mode %h done", rows[r].cfg);
		end
		// Three of four bytes must stay hidden
		rrate <= 0;
		apb(1, FNP_CTRL_OFS, 32'h0000_001c);
		for (k = 0; k < 3; k++)
			send(sv(k), 0);
		repeat (4) @(posedge pclk);
		chk(out_valid, 0);
		send(sv(3), 0);
		await(2, 1);
		chk(sink_u.got.pop_front(), (sv(0) << 30) | (sv(1) << 20) | (sv(2) << 10) | sv(3));
		// Stalled reader: two words fill the buffer, input refused
		hold <= 1;
		apb(1, FNP_CTRL_OFS, 0);
		send(sv(5), 0);
		send(sv(6), 0);
		repeat (2) @(negedge pclk);
		chk(in_ready, 0);
		// Level two, no slices held, plain mode counts as valid
		apb(0, FNP_STATUS_OFS, 0);
		chk(rd, 32'h0000_0102);
		hold <= 0;
		await(2, 2);
		chk(sink_u.got.pop_front(), sv(5));
		chk(sink_u.got.pop_front(), sv(6));
		// Eight row words, one hidden-slice word, two stalled words
		apb(0, FNP_WORDS_OFS, 0);
		chk(rd, 32'h0000_000b);
		$display("awkward cases done");
		final_report();
	end
endmodule // fifo_narrow_to_wide_packer_bench

// *** tb/fnp_packer_asserts.sv ***
// Port-level checks for the packer: APB answer, refusal, stream hold.
// Bound into every fnp_packer; single pclk domain.
`timescale 1ns/100ps
module fnp_packer_asserts (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              in_valid,
	input wire logic              in_ready,
	input wire logic              out_valid,
	input wire logic              out_ready,
	input wire fnp_pkg::fnp_out_t out_data
);
	import fnp_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// The two APB steps
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable; endsequence
	a_apb_answer: assert property (s_setup ##1 s_access |-> pready) else $error("no answer");
	a_ready_access: assert property (pready |-> s_access) else $error("stray ready");
	a_err_pair: assert property (pslverr |-> pready) else $error("error without ready");
	a_err_unmapped: assert property (pready && !pwrite && paddr > FNP_WORDS_OFS
		|-> pslverr && prdata == 32'h0000_0000) else $error("unmapped read accepted");
	a_ok_mapped: assert property (pready && (paddr == FNP_CTRL_OFS || paddr == FNP_STATUS_OFS
		|| paddr == FNP_WORDS_OFS) |-> !pslverr)
		else $error("mapped access refused");
	a_ctrl_block: assert property (pready && pwrite && paddr == FNP_CTRL_OFS |=> !in_ready)
		else $error("input open after control write");
	// Oldest word only: a single-rate reader may see the second entry fill behind it
	a_out_held: assert property (out_valid && !out_ready |=> out_valid
		&& $stable(out_data.word_rise))
		else $error("word changed before taken");
	a_word_cause: assert property ($rose(out_valid) |-> $past(in_valid && in_ready))
		else $error("word without input");
endmodule // fnp_packer_asserts

bind fnp_packer fnp_packer_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
	.out_ready(out_ready), .out_data(out_data));

// *** tb/fnp_sink.sv ***
// Consumer model for the packer's read side; queues every word taken.
// Assumes rrate mirrors the read rate select in force.
`timescale 1ns/100ps
module fnp_sink (
	input  wire logic              pclk,
	input  wire logic              out_valid,
	input  wire fnp_pkg::fnp_out_t out_data,
	input  wire logic              rrate,
	input  wire logic              hold,
	output logic                   out_ready
);
	import fnp_pkg::*;
	logic [FNP_WORD_W-1:0] got[$];
	logic                  ph_q = 1'b0;
	// Takes every other cycle, so the buffer sees a slow reader
	always @(posedge pclk) begin
		ph_q <= !ph_q;
		if (out_valid && out_ready) begin
			got.push_back(out_data.word_rise);
			if (rrate)
				got.push_back(out_data.word_fall);
		end
	end
	assign out_ready = ph_q && !hold;
endmodule // fnp_sink
